// *** design/neg_seq_overcurrent_fn.sv ***
/*
 * Timing and decision core of the negative-sequence overcurrent function with its APB
 * register file and interrupt. Assumes the magnitude input is produced on pclk by the
 * upstream measurement stage, in units of 0.1 % of rated current.
 */
// How it works
// - ANSI reset time is TMS times kr over one minus ratio squared.
// - IEC inverse curves clear progress after the fixed reset delay instead.
// - ANSI reset constants use exponent 2 and the listed kr values.
// - Inverse operate time never drops below the minimum delay, 40 to 60000 ms.
// - Curve selection: off, definite time, four IEC, seven ANSI; default off.
// - Start threshold in percent of rated current, 10 to 1000, default 50.
// - Time multiplier for inverse curves, 0.05 to 15 in 0.01 steps, default 1.
// - Definite time trips after a fixed delay of 40 to 60000 ms, default 100.
// - Fixed reset delay for IEC inverse curves is 60 to 60000 ms, default 100.
// - Two outputs are driven: a start flag and a trip flag.
// - Trip rises only after the characteristic delay expired while still started.
// - Inverse operate time is TMS times the sum of k over ratio to alpha minus one and c.
// - Above twenty times the start value the operate time stays at that limit.
// - Start is raised while the magnitude exceeds the start threshold.
`timescale 1ns/1ns

module neg_seq_overcurrent_fn #(
    parameter int TICK_CYCLES = neg_seq_pkg::TICK_US * neg_seq_pkg::CLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] neg_seq_magnitude,
    input wire logic block_input,
    output logic start_flag,
    output logic trip_flag,
    output logic irq
);

    localparam logic [63:0] TICK_SCALED = 64'(neg_seq_pkg::TICK_US) << neg_seq_pkg::SCALE_BITS;
    localparam logic [24:0] ACC_FULL = 25'h100_0000;

    neg_seq_pkg::settings_s cfg;
    logic [31:0] tick_cnt;
    logic tick;
    logic started;
    logic [24:0] acc;
    logic [15:0] reset_ticks;
    logic [neg_seq_pkg::INT_BITS-1:0] int_status;
    logic [neg_seq_pkg::INT_BITS-1:0] int_mask;

    function automatic logic [31:0] log2_q16(input logic [31:0] r);
        logic [2:0] n;
        logic [31:0] frac;
        n = 3'h0;
        for (int i = 1; i < 5; i++) begin
            if (r[16+i]) begin
                n = 3'(i);
            end
        end
        frac = (r >> n) - neg_seq_pkg::RATIO_ONE;
        return {13'h0, n, frac[15:0]};
    endfunction

    // Measured ratio G/Gs in Q16 and the curve constants in use.
    wire [15:0] gs10 = 16'(cfg.start_pct) * 16'h000a;
    wire [47:0] ratio_wide = {16'h0, neg_seq_magnitude, 16'h0} / {32'h0, gs10};
    wire [31:0] ratio = (ratio_wide[47:32] != 16'h0) ? 32'hffff_ffff : ratio_wide[31:0];
    wire neg_seq_pkg::curve_s cc = neg_seq_pkg::curve_consts(cfg.curve);
    wire is_off = (cfg.curve == neg_seq_pkg::curve_off);
    wire is_dt = (cfg.curve == neg_seq_pkg::definite_time_choice);
    wire is_iec = (cfg.curve >= neg_seq_pkg::iec_inv) && (cfg.curve <= neg_seq_pkg::iec_long_inv);
    wire is_ansi = (cfg.curve >= neg_seq_pkg::ansi_inv);
    wire over_start = (neg_seq_magnitude > gs10);

    // Operate time of the inverse curves, ratio clamped at twenty times the start value.
    wire [31:0] r_op = (ratio > neg_seq_pkg::RATIO_LIMIT) ? neg_seq_pkg::RATIO_LIMIT : ratio;
    wire [63:0] r_op_sq = (64'(r_op) * 64'(r_op)) >> 16;
    wire [63:0] pm1_small = (64'(log2_q16(r_op)) * neg_seq_pkg::LOG_TO_PM1) >> 16;
    wire [63:0] pm1_raw = (cc.alpha == neg_seq_pkg::alpha_two) ? r_op_sq - 64'(neg_seq_pkg::RATIO_ONE) :
        (cc.alpha == neg_seq_pkg::alpha_one) ? 64'(r_op) - 64'(neg_seq_pkg::RATIO_ONE) : pm1_small;
    wire [63:0] pm1 = (pm1_raw == 64'h0) ? 64'h1 : pm1_raw;
    wire [63:0] base_us = ((64'(cc.k_us) << 16) / pm1) + 64'(cc.c_us);
    wire [63:0] inv_us = (base_us * 64'(cfg.tms_hundredths)) / 64'd100;
    wire [63:0] min_us = 64'(cfg.min_ms) * 64'd1000;
    wire [63:0] def_us = 64'(cfg.def_ms) * 64'd1000;
    wire [63:0] inv_limited_us = (inv_us < min_us) ? min_us : inv_us;
    wire [63:0] op_us = is_dt ? def_us : inv_limited_us;
    wire [63:0] op_step = TICK_SCALED / op_us;

    // Dependent reset time of the ANSI curves below the start value.
    wire [63:0] r_sq = (64'(ratio) * 64'(ratio)) >> 16;
    wire [63:0] rs_raw = (r_sq < 64'(neg_seq_pkg::RATIO_ONE)) ? 64'(neg_seq_pkg::RATIO_ONE) - r_sq : 64'h1;
    wire [63:0] rs = (rs_raw == 64'h0) ? 64'h1 : rs_raw;
    wire [63:0] rst_base_us = (64'(cc.kr_us) << 16) / rs;
    wire [63:0] rst_us = (rst_base_us * 64'(cfg.tms_hundredths)) / 64'd100;
    wire [63:0] rst_step = TICK_SCALED / ((rst_us == 64'h0) ? 64'h1 : rst_us);

    wire [25:0] acc_up = 26'(acc) + 26'(op_step[24:0]);
    wire [24:0] acc_down = (25'(rst_step[24:0]) > acc) ? 25'h0 : acc - 25'(rst_step[24:0]);
    wire next_started = over_start && !is_off && !block_input;
    wire next_trip = next_started && (acc == ACC_FULL);

    logic [24:0] next_acc;
    logic [15:0] next_reset_ticks;
    always_comb begin
        next_acc = acc;
        next_reset_ticks = reset_ticks;
        if (is_off || block_input) begin
            next_acc = 25'h0;
            next_reset_ticks = 16'h0;
        end else if (!tick) begin
            next_acc = acc;
        end else if (over_start) begin
            next_reset_ticks = 16'h0;
            next_acc = (acc_up >= 26'(ACC_FULL)) ? ACC_FULL : acc_up[24:0];
        end else if (is_ansi) begin
            next_acc = acc_down;
        end else if (is_iec) begin
            next_reset_ticks = reset_ticks + 16'h1;
            if (next_reset_ticks >= cfg.reset_ms) begin
                next_acc = 25'h0;
            end
        end else begin
            next_acc = 25'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 25'h0;
            reset_ticks <= 16'h0;
            started <= 1'b0;
            start_flag <= 1'b0;
            trip_flag <= 1'b0;
        end else begin
            acc <= next_acc;
            reset_ticks <= next_reset_ticks;
            started <= next_started;
            start_flag <= next_started;
            trip_flag <= next_trip;
        end
    end

    // APB decode; the slave always answers in the access cycle.
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_ctrl = (paddr == neg_seq_pkg::CTRL_OFS);
    wire hit_start = (paddr == neg_seq_pkg::START_OFS);
    wire hit_tms = (paddr == neg_seq_pkg::TMS_OFS);
    wire hit_min = (paddr == neg_seq_pkg::MIN_DELAY_OFS);
    wire hit_def = (paddr == neg_seq_pkg::DEF_DELAY_OFS);
    wire hit_rst = (paddr == neg_seq_pkg::RESET_DELAY_OFS);
    wire hit_stat = (paddr == neg_seq_pkg::STATUS_OFS);
    wire hit_int = (paddr == neg_seq_pkg::INT_STATUS_OFS);
    wire hit_mask = (paddr == neg_seq_pkg::INT_MASK_OFS);
    wire mapped = hit_ctrl || hit_start || hit_tms || hit_min || hit_def || hit_rst ||
        hit_stat || hit_int || hit_mask;
    wire curve_ok = (pwdata[31:4] == 28'h0) && (pwdata[3:0] <= 4'(neg_seq_pkg::ansi_long_ext_inv));
    wire start_ok = (pwdata >= 32'(neg_seq_pkg::START_MIN)) && (pwdata <= 32'(neg_seq_pkg::START_MAX));
    wire tms_ok = (pwdata >= 32'(neg_seq_pkg::TMS_MIN)) && (pwdata <= 32'(neg_seq_pkg::TMS_MAX));
    wire op_ok = (pwdata >= 32'(neg_seq_pkg::OP_DELAY_MIN)) && (pwdata <= 32'(neg_seq_pkg::DELAY_MAX));
    wire rst_ok = (pwdata >= 32'(neg_seq_pkg::RESET_DELAY_MIN)) &&
        (pwdata <= 32'(neg_seq_pkg::DELAY_MAX));

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit_ctrl) begin
            rd_mux = {28'h0, cfg.curve};
        end else if (hit_start) begin
            rd_mux = {22'h0, cfg.start_pct};
        end else if (hit_tms) begin
            rd_mux = {21'h0, cfg.tms_hundredths};
        end else if (hit_min) begin
            rd_mux = {16'h0, cfg.min_ms};
        end else if (hit_def) begin
            rd_mux = {16'h0, cfg.def_ms};
        end else if (hit_rst) begin
            rd_mux = {16'h0, cfg.reset_ms};
        end else if (hit_stat) begin
            rd_mux = {acc[24:1], 5'h0, block_input, trip_flag, start_flag};
        end else if (hit_int) begin
            rd_mux = {29'h0, int_status};
        end else if (hit_mask) begin
            rd_mux = {29'h0, int_mask};
        end
    end

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup) begin
            prdata <= rd_mux;
        end
    end

    // Settings; out-of-range writes are ignored so the settings stay in range.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.curve <= neg_seq_pkg::curve_off;
            cfg.start_pct <= neg_seq_pkg::START_RST;
            cfg.tms_hundredths <= neg_seq_pkg::TMS_RST;
            cfg.min_ms <= neg_seq_pkg::DELAY_RST;
            cfg.def_ms <= neg_seq_pkg::DELAY_RST;
            cfg.reset_ms <= neg_seq_pkg::DELAY_RST;
        end else if (wr) begin
            if (hit_ctrl && curve_ok) begin
                cfg.curve <= neg_seq_pkg::curve_e'(pwdata[3:0]);
            end
            if (hit_start && start_ok) begin
                cfg.start_pct <= pwdata[9:0];
            end
            if (hit_tms && tms_ok) begin
                cfg.tms_hundredths <= pwdata[10:0];
            end
            if (hit_min && op_ok) begin
                cfg.min_ms <= pwdata[15:0];
            end
            if (hit_def && op_ok) begin
                cfg.def_ms <= pwdata[15:0];
            end
            if (hit_rst && rst_ok) begin
                cfg.reset_ms <= pwdata[15:0];
            end
        end
    end

    // Sticky event bits; a new event wins over a write-one-to-clear in the same cycle.
    wire [neg_seq_pkg::INT_BITS-1:0] events = {
        started && !next_started,
        !trip_flag && next_trip,
        !started && next_started
    };
    wire [neg_seq_pkg::INT_BITS-1:0] clr = (wr && hit_int) ?
        pwdata[neg_seq_pkg::INT_BITS-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
            int_mask <= '0;
            irq <= 1'b0;
        end else begin
            int_status <= (int_status & ~clr) | events;
            if (wr && hit_mask) begin
                int_mask <= pwdata[neg_seq_pkg::INT_BITS-1:0];
            end
            irq <= |(((int_status & ~clr) | events) & int_mask);
        end
    end

endmodule

// *** design/neg_seq_pkg.sv ***
/*
 * Package for the negative-sequence overcurrent timing core: register map, setting
 * ranges and reset values, curve enumeration and per-curve constants.
 * Assumes a 100 MHz APB clock and a 1 ms processing tick derived from it.
 */
package neg_seq_pkg;

    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1000;
    localparam int SCALE_BITS = 24;
    localparam logic [31:0] RATIO_ONE = 32'h0001_0000;
    localparam logic [31:0] RATIO_LIMIT = 32'h0014_0000;
    localparam logic [63:0] LOG_TO_PM1 = 64'h0000_0000_0000_038d;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] START_OFS = 8'h04;
    localparam logic [7:0] TMS_OFS = 8'h08;
    localparam logic [7:0] MIN_DELAY_OFS = 8'h0c;
    localparam logic [7:0] DEF_DELAY_OFS = 8'h10;
    localparam logic [7:0] RESET_DELAY_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] INT_STATUS_OFS = 8'h1c;
    localparam logic [7:0] INT_MASK_OFS = 8'h20;

    localparam logic [9:0] START_MIN = 10'h00a;
    localparam logic [9:0] START_MAX = 10'h3e8;
    localparam logic [9:0] START_RST = 10'h032;
    localparam logic [10:0] TMS_MIN = 11'h005;
    localparam logic [10:0] TMS_MAX = 11'h5dc;
    localparam logic [10:0] TMS_RST = 11'h064;
    localparam logic [15:0] OP_DELAY_MIN = 16'h0028;
    localparam logic [15:0] RESET_DELAY_MIN = 16'h003c;
    localparam logic [15:0] DELAY_MAX = 16'hea60;
    localparam logic [15:0] DELAY_RST = 16'h0064;

    localparam int INT_START_RISE = 0;
    localparam int INT_TRIP_RISE = 1;
    localparam int INT_START_FALL = 2;
    localparam int INT_BITS = 3;

    typedef enum logic [3:0] {
        curve_off, definite_time_choice, iec_inv, iec_very_inv, iec_ext_inv, iec_long_inv,
        ansi_inv, ansi_mod_inv, ansi_very_inv, ansi_ext_inv, ansi_long_inv,
        ansi_long_very_inv, ansi_long_ext_inv
    } curve_e;

    typedef enum logic [1:0] {alpha_small, alpha_one, alpha_two} alpha_e;

    typedef struct packed {
        curve_e curve;
        logic [9:0] start_pct;
        logic [10:0] tms_hundredths;
        logic [15:0] min_ms;
        logic [15:0] def_ms;
        logic [15:0] reset_ms;
    } settings_s;

    typedef struct packed {
        logic [31:0] k_us;
        logic [31:0] c_us;
        logic [31:0] kr_us;
        alpha_e alpha;
    } curve_s;

    function automatic curve_s curve_consts(input curve_e sel);
        curve_s r;
        r = '{k_us: 32'h0, c_us: 32'h0, kr_us: 32'h0, alpha: alpha_small};
        case (sel)
            iec_inv: r = '{32'h0002_2260, 32'h0, 32'h0, alpha_small};
            iec_very_inv: r = '{32'h00cd_fe60, 32'h0, 32'h0, alpha_one};
            iec_ext_inv: r = '{32'h04c4_b400, 32'h0, 32'h0, alpha_two};
            iec_long_inv: r = '{32'h0727_0e00, 32'h0, 32'h0, alpha_one};
            ansi_inv: r = '{32'h0000_2198, 32'h0000_4844, 32'h0007_04e0, alpha_small};
            ansi_mod_inv: r = '{32'h0000_c92c, 32'h0001_bd50, 32'h004a_01d0, alpha_small};
            ansi_very_inv: r = '{32'h012b_3930, 32'h0007_7dfc, 32'h0149_9700, alpha_two};
            ansi_ext_inv: r = '{32'h01ae_4d40, 32'h0001_db64, 32'h01bc_0a60, alpha_two};
            ansi_long_inv: r = '{32'h0001_4ff0, 32'h0002_d2a8, 32'h0046_30c0, alpha_small};
            ansi_long_very_inv: r = '{32'h01b3_a3f0, 32'h000a_dd40, 32'h00cd_6160, alpha_two};
            ansi_long_ext_inv: r = '{32'h03d1_a3b0, 32'h0003_d090, 32'h01c9_c380, alpha_two};
            default: r = '{k_us: 32'h0, c_us: 32'h0, kr_us: 32'h0, alpha: alpha_small};
        endcase
        return r;
    endfunction

endpackage

// *** sim/meas_source.sv ***
/* Model of the upstream measurement stage and the user blocking logic.
   Assumes the bench sets the wanted level and block request on pclk. */
`timescale 1ns/1ns
module meas_source (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] level,
    input wire logic hold_off,
    output logic [15:0] neg_seq_magnitude,
    output logic block_input
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_seq_magnitude <= 16'h0000;
            block_input <= 1'b0;
        end else begin
            neg_seq_magnitude <= level;
            block_input <= hold_off;
        end
    end
endmodule

// *** sim/neg_seq_sva.sv ***
/* Checker of the timing core seen at its ports, bound to the top module.
   Assumes the magnitude is in 0.1 % of rated current and writes complete in one access. */
`timescale 1ns/1ns
module neg_seq_sva #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] neg_seq_magnitude,
    input wire logic block_input,
    input wire logic start_flag,
    input wire logic trip_flag,
    input wire logic irq
);
    logic [3:0] curve_sel;
    logic [9:0] thr;
    wire wr_now = psel && penable && pwrite;
    wire over = neg_seq_magnitude > ({6'h00, thr} * 16'h000a);
    wire bad_addr = paddr > neg_seq_pkg::INT_MASK_OFS || paddr[1:0] != 2'b00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            curve_sel <= 4'h0;
            thr <= neg_seq_pkg::START_RST;
        end else if (wr_now && paddr == neg_seq_pkg::CTRL_OFS
                     && pwdata <= 32'(neg_seq_pkg::ansi_long_ext_inv)) begin
            curve_sel <= pwdata[3:0];
        end else if (wr_now && paddr == neg_seq_pkg::START_OFS
                     && pwdata >= 32'(neg_seq_pkg::START_MIN)
                     && pwdata <= 32'(neg_seq_pkg::START_MAX)) begin
            thr <= pwdata[9:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_slverr; psel && penable |-> pready && pslverr == bad_addr; endproperty
    a_slverr: assert property (p_slverr) else $error("bad error response");
    property p_rd_stable; psel && penable |=> $stable(prdata); endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
    property p_start_on; !block_input && curve_sel != 4'h0 && over |=> start_flag; endproperty
    a_start_on: assert property (p_start_on) else $error("start missing");
    property p_start_off; !over |=> !start_flag; endproperty
    a_start_off: assert property (p_start_off) else $error("start too early");
    property p_block; block_input |=> !start_flag && !trip_flag; endproperty
    a_block: assert property (p_block) else $error("flags while blocked");
    property p_off; curve_sel == 4'h0 |=> !start_flag && !trip_flag; endproperty
    a_off: assert property (p_off) else $error("flags while off");
    property p_trip_cause; $rose(trip_flag) |-> start_flag; endproperty
    a_trip_cause: assert property (p_trip_cause) else $error("trip unstarted");
    property p_trip_drop; $fell(start_flag) |-> ##[0:1] !trip_flag; endproperty
    a_trip_drop: assert property (p_trip_drop) else $error("trip held");
    property p_irq_mask;
        wr_now && paddr == neg_seq_pkg::INT_MASK_OFS && pwdata[2:0] == 3'h0 |=> ##1 !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    c_trip: cover property ($rose(trip_flag));
    c_irq: cover property ($rose(irq));
    c_err: cover property (psel && penable && pslverr);
endmodule
bind neg_seq_overcurrent_fn neg_seq_sva #(.TICK_CYCLES(TICK_CYCLES)) neg_seq_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .neg_seq_magnitude(neg_seq_magnitude), .block_input(block_input),
    .start_flag(start_flag), .trip_flag(trip_flag), .irq(irq));

// *** sim/test_neg_seq_overcurrent_fn.sv ***
/* Self-checking bench of the timing core over APB with a measurement source model.
   Assumes a 10 cycle tick, so every millisecond figure counts ticks. */
`timescale 1ns/1ns
module test_neg_seq_overcurrent_fn;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, start_flag, trip_flag, irq, block_input, blk = 1'b0;
    logic [15:0] mag = 16'h0000, neg_seq_magnitude;
    int n_errors = 0, comparisons = 0, n;
    logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    logic [31:0] rv[7] = '{32'h0, 32'h32, 32'h64, 32'h64, 32'h64, 32'h64, 32'h0};
    logic [7:0] ba[7] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] good[7] = '{32'h3e8, 32'ha, 32'h5dc, 32'h5, 32'h28, 32'hea60, 32'h3c};
    logic [31:0] bad[7] = '{32'h3e9, 32'h9, 32'h5dd, 32'h4, 32'h27, 32'hea61, 32'h3b};
    always #5 pclk = ~pclk;
    neg_seq_overcurrent_fn #(.TICK_CYCLES(10)) neg_seq_overcurrent_fn_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .neg_seq_magnitude(neg_seq_magnitude), .block_input(block_input),
        .start_flag(start_flag), .trip_flag(trip_flag), .irq(irq));
    meas_source meas_source_inst (.pclk(pclk), .presetn(presetn), .level(mag), .hold_off(blk),
        .neg_seq_magnitude(neg_seq_magnitude), .block_input(block_input));
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic check_time(input string what, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
            n_errors++;
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 100);
        if (i == 100) begin
            n_errors++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic trip_time(input logic [15:0] m, output int t);
        blk <= 1'b1;
        repeat (3) @(posedge pclk);
        blk <= 1'b0;
        mag <= m;
        t = 0;
        while (trip_flag !== 1'b1 && t < 3000) begin
            @(posedge pclk);
            t++;
        end
        if (t == 3000) begin
            n_errors++;
            complete_run();
        end
        mag <= 16'h0000;
        @(posedge pclk);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check("reset value", rv[i], rd);
        end
        for (int c = 0; c < 14; c++) begin
            apb(1'b1, 8'h00, 32'(c));
            apb(1'b0, 8'h00, 32'h0);
            check("curve select", (c < 13) ? 32'(c) : 32'hc, rd);
        end
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ba[i], good[i]);
            apb(1'b1, ba[i], bad[i]);
            apb(1'b0, ba[i], 32'h0);
            check("range limit", good[i], rd);
        end
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h32);
        apb(1'b1, 8'h10, 32'h28);
        mag <= 16'h03e8;
        repeat (30) @(posedge pclk);
        check("flags while off", 32'h0, {30'h0, trip_flag, start_flag});
        apb(1'b1, 8'h00, 32'h1);
        mag <= 16'h01f4;
        repeat (4) @(posedge pclk);
        check("start at threshold", 32'h0, {31'h0, start_flag});
        apb(1'b1, 8'h20, 32'h2);
        apb(1'b1, 8'h1c, 32'h7);
        trip_time(16'h01f5, n);
        check_time("definite trip cycles", 400, 440, n);
        repeat (3) @(posedge pclk);
        check("trip interrupt", 32'h1, {31'h0, irq});
        apb(1'b0, 8'h1c, 32'h0);
        check("trip status", 32'h2, rd & 32'h2);
        apb(1'b1, 8'h1c, 32'h7);
        repeat (2) @(posedge pclk);
        check("interrupt cleared", 32'h0, {31'h0, irq});
        blk <= 1'b1;
        mag <= 16'h01f5;
        repeat (5) @(posedge pclk);
        check("blocked flags", 32'h0, {30'h0, trip_flag, start_flag});
        blk <= 1'b0;
        repeat (5) @(posedge pclk);
        check("start and masked irq", 32'h2, {30'h0, start_flag, irq});
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h08, 32'h14);
        trip_time(16'h2710, n);
        check_time("inverse trip cycles", 1340, 1520, n);
        trip_time(16'h4e20, n);
        check_time("clamped trip cycles", 1340, 1520, n);
        apb(1'b1, 8'h08, 32'h5);
        apb(1'b1, 8'h0c, 32'h3c);
        trip_time(16'h2710, n);
        check_time("minimum delay cycles", 600, 650, n);
        repeat (300) @(posedge pclk);
        apb(1'b0, 8'h18, 32'h0);
        check("iec held progress", 32'h0080_0000, rd >> 8);
        repeat (400) @(posedge pclk);
        apb(1'b0, 8'h18, 32'h0);
        check("iec cleared progress", 32'h0, rd >> 8);
        apb(1'b1, 8'h00, 32'h6);
        apb(1'b1, 8'h08, 32'h14);
        trip_time(16'h2710, n);
        check_time("ansi trip cycles", 600, 650, n);
        repeat (460) @(posedge pclk);
        apb(1'b0, 8'h18, 32'h0);
        check_time("ansi reset", 4100000, 4290000, int'(rd >> 8));
        apb(1'b1, 8'h20, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, 8'h1c, 32'h0);
        check("sticky status", 32'h7, rd & 32'h7);
        complete_run();
    end
endmodule
